// *** design/eeprom_link_pkg.sv ***
// shared constants for the serial eeprom pause / supply-guard link
// assumes both ends import this package; no clock or reset lives here
package eeprom_link_pkg;
  // command codes on the serial line
  localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_RD = 8'h05;
  localparam logic [7:0] CMD_STATUS_WR = 8'h01;
  localparam logic [7:0] CMD_MEM_WR = 8'h02;
  // status byte layout and reset value
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // frame layout in sck rising edges
  localparam logic [5:0] CNT_CMD_LAST = 6'h07;
  localparam logic [5:0] CNT_SR_LAST = 6'h0f;
  localparam logic [5:0] CNT_ADDR_HI_LAST = 6'h0f;
  localparam logic [5:0] CNT_ADDR_LO_LAST = 6'h17;
  localparam logic [5:0] CNT_DATA_FIRST = 6'h1f;
  localparam logic [5:0] CNT_OUT_LOAD = 6'h08;
  // host sck half period in ref_clk cycles, and the least it may be
  localparam int SCK_HALF_DIV = 5;
  localparam int SCK_HALF_MIN = 3;
  // frame phase of the device end
  typedef enum logic [2:0] {PH_CMD, PH_MEM_WR, PH_STATUS_WR, PH_STATUS_RD, PH_IGNORE} phase_e;
endpackage

// *** design/eeprom_link_if.sv ***
// serial link between host end and eeprom end, with the data-out wire resolved
// assumes the device end drives miso only while miso_oe is high
`timescale 1ns/1ps
interface eeprom_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic hold_n;
  logic miso;
  logic miso_oe;
  wire miso_line;

  // an undriven data-out line shows the inverse of the last bit, so a host
  // that samples it while the device has let go sees a wrong value
  assign miso_line = miso_oe ? miso : !miso;

  modport device (input cs_n, input sck, input mosi, input hold_n,
                  output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, output hold_n,
                input miso_line);
endinterface

// *** design/spi_eeprom_end.sv ***
// eeprom end of the link: pause handling, latch and write arming, supply guard
// assumes sck is mode 0 from the host; low_supply comes from a voltage detector
// assumes the write engine answers an issued write with wr_ack
// Summary of operation
// - paused: output floats, clock and input ignored
// - host keeps select low throughout pause
// - deselect during pause ends the transfer
// - pause falls, clock low: pause immediately
// - pause rises, clock low: resume immediately
// - pause falls, clock high: wait clock fall
// - pause rises, clock high: resume at fall
// - low supply aborts pending memory/status writes
// - low supply clears write enable latch
// - host re-enables latch after supply recovers
// - no write while select is low
// - host avoids select and clock rising together
// - memory write refused unless latch set
`timescale 1ns/1ps
module spi_eeprom_end
  import eeprom_link_pkg::*;
(
  // serial link, clocked by the host's sck
  eeprom_link_if.device link,
  // supply detector and write engine side
  input wire logic low_supply,
  input wire logic busy,
  input wire logic wr_ack,
  // armed writes, issued once select goes high
  output logic mem_wr_go,
  output logic [15:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output logic status_wr_go,
  output logic [7:0] status_wr_data,
  // state for observation
  output logic write_enable_latch,
  output logic paused
);

  logic [5:0] cnt;
  logic [6:0] shreg;
  logic [15:0] addr;
  phase_e phase;
  logic hold_at_fall;
  logic [7:0] out_sr;
  logic busy_s1;
  logic busy_s2;
  logic mem_pend;
  logic sr_pend;

  // transfer state is cleared by deselect as well as by the supply detector
  wire xfer_rst = link.cs_n | low_supply;
  wire pend_clr = low_supply | wr_ack;
  // the pause pin is read as it stands: entry must not wait for a sync stage
  wire shift_en = link.hold_n;
  // byte completed by the bit arriving at this rise
  wire [7:0] new_byte = {shreg, link.mosi};
  // frame position, counted in sck rises
  wire byte_end = (cnt[2:0] == 3'h7);
  wire cmd_end = (cnt == CNT_CMD_LAST);
  wire data_end = byte_end && (cnt >= CNT_DATA_FIRST) && (phase == PH_MEM_WR);
  wire sr_end = (cnt == CNT_SR_LAST) && (phase == PH_STATUS_WR);
  // a write command is refused while a write runs or the latch is clear
  wire refuse = busy_s2 || !write_enable_latch;
  // status byte as shifted out: latch in bit 1, busy in bit 0
  wire [7:0] status = {6'h00, write_enable_latch, busy_s2};

  // pause seen by the core: follows the pin while sck is low, else the
  // value taken at the last sck fall, so entry and exit wait for the fall
  assign paused = !link.cs_n && (link.sck ? hold_at_fall : !link.hold_n);

  // pause sample at each sck fall
  // cleared by deselect so that a new frame never starts paused
  always_ff @(negedge link.sck or posedge xfer_rst)
  begin
    if (xfer_rst)
      hold_at_fall <= 1'b0;
    else
      hold_at_fall <= !link.hold_n;
  end

  // busy comes from the write engine's domain, so it is resynchronised
  // two rises of latency: a command right after busy rises may still pass
  always_ff @(posedge link.sck or posedge low_supply)
  begin
    if (low_supply)
    begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end
    else
    begin
      busy_s1 <= busy;
      busy_s2 <= busy_s1;
    end
  end

  // bit counter, input shifter and phase; a rising edge while paused is ignored
  always_ff @(posedge link.sck or posedge xfer_rst)
  begin
    if (xfer_rst)
    begin
      cnt <= 6'h00;
      shreg <= 7'h00;
      addr <= 16'h0000;
      phase <= PH_CMD;
    end
    else if (shift_en)
    begin
      shreg <= new_byte[6:0];
      if (cnt != 6'h3f)
        cnt <= cnt + 6'h01;
      else
        cnt <= 6'h38; // keeps counting whole bytes on long page writes
      if (cnt == CNT_ADDR_HI_LAST && phase == PH_MEM_WR)
        addr[15:8] <= new_byte;
      if (cnt == CNT_ADDR_LO_LAST && phase == PH_MEM_WR)
        addr[7:0] <= new_byte;
      if (data_end)
        addr[5:0] <= addr[5:0] + 6'h01; // low bits wrap within the page
      if (cmd_end)
      begin
        case (new_byte)
          CMD_MEM_WR: phase <= refuse ? PH_IGNORE : PH_MEM_WR;
          CMD_STATUS_WR: phase <= refuse ? PH_IGNORE : PH_STATUS_WR;
          CMD_STATUS_RD: phase <= PH_STATUS_RD;
          default: phase <= PH_IGNORE;
        endcase
      end
    end
  end

  // write enable latch survives deselect; the detector clears it at once
  // a refused write command leaves the latch as it was
  always_ff @(posedge link.sck or posedge low_supply)
  begin
    if (low_supply)
      write_enable_latch <= 1'b0;
    else if (!link.cs_n && shift_en && cmd_end && !busy_s2)
    begin
      if (new_byte == CMD_WR_ENABLE)
        write_enable_latch <= 1'b1;
      else if (new_byte == CMD_WR_DISABLE)
        write_enable_latch <= 1'b0;
      else if (new_byte == CMD_MEM_WR || new_byte == CMD_STATUS_WR)
        write_enable_latch <= 1'b0; // consumed by the write it enables
    end
  end

  // armed writes: a stray bit after a whole byte cancels the arming
  // a frame of another kind leaves an earlier arming standing
  always_ff @(posedge link.sck or posedge pend_clr)
  begin
    if (pend_clr)
    begin
      mem_pend <= 1'b0;
      sr_pend <= 1'b0;
      mem_wr_addr <= 16'h0000;
      mem_wr_data <= 8'h00;
      status_wr_data <= STATUS_RESET;
    end
    else if (!link.cs_n && shift_en)
    begin
      if (data_end)
      begin
        mem_pend <= 1'b1;
        mem_wr_addr <= addr;
        mem_wr_data <= new_byte;
      end
      else if (!byte_end && phase == PH_MEM_WR)
        mem_pend <= 1'b0; // any bit of a write frame that ends no byte cancels, address bits too
      if (sr_end)
      begin
        sr_pend <= 1'b1;
        status_wr_data <= new_byte;
      end
      else if (phase == PH_STATUS_WR)
        sr_pend <= 1'b0;
    end
  end

  // writes start only after deselect, so nothing is issued while select is
  // low; a clear by the detector wins over any arming in flight
  // the go levels stand while select is high, until the engine acknowledges or the supply dips
  assign mem_wr_go = mem_pend && link.cs_n && !low_supply;
  assign status_wr_go = sr_pend && link.cs_n && !low_supply;

  // status byte shifted out on sck falls, frozen while paused; the pause
  // state of the high phase decides, so the fall that ends a pause (whose
  // rise was ignored) does not shift
  always_ff @(negedge link.sck or posedge xfer_rst)
  begin
    if (xfer_rst)
      out_sr <= 8'h00;
    else if (!hold_at_fall)
    begin
      if (cnt == CNT_OUT_LOAD && phase == PH_STATUS_RD)
        out_sr <= status;
      else
        out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  // data out floats while paused or not reading
  // the line is driven from the rise that completes the command byte onwards
  assign link.miso = out_sr[7];
  assign link.miso_oe = !link.cs_n && !paused && phase == PH_STATUS_RD
                        && cnt >= CNT_OUT_LOAD;

endmodule

// *** design/spi_host_end.sv ***
// host end of the link: frames of 1 to 4 bytes, pause on request
// assumes one ref_clk domain; sck is divided down from ref_clk and driven out
`timescale 1ns/1ps
module spi_host_end
  import eeprom_link_pkg::*;
#(
  parameter int HALF_DIV = SCK_HALF_DIV
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // serial link
  eeprom_link_if.host link,
  // user request side
  input wire logic start,
  input wire logic [2:0] len,
  input wire logic [31:0] tx_data,
  input wire logic pause,
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte
);

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL} host_state_e;

  // sampling miso through two flops needs at least three cycles of half period
  if (HALF_DIV < SCK_HALF_MIN || HALF_DIV > 255)
  begin : g_bad_half_div
    $error("HALF_DIV out of range");
  end

  host_state_e state;
  logic [7:0] div;
  logic [5:0] bits;
  logic [31:0] sh;
  logic [7:0] rx;
  logic miso_s1;
  logic miso_s2;
  logic cs_n;
  logic sck;
  logic hold_n;

  wire tick = (div == 8'(HALF_DIV - 1));
  wire [2:0] len_ok = (len == 3'h0 || len > 3'h4) ? 3'h1 : len;

  assign link.cs_n = cs_n;
  assign link.sck = sck;
  assign link.mosi = sh[31];
  assign link.hold_n = hold_n;
  assign busy = (state != H_IDLE);

  // miso comes from the device's sck domain
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end
    else
    begin
      miso_s1 <= link.miso_line;
      miso_s2 <= miso_s1;
    end
  end

  // half-period divider, restarted on every phase change
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      div <= 8'h00;
    else if (state == H_IDLE || tick)
      div <= 8'h00;
    else
      div <= div + 8'h01;
  end

  // frame sequencer; select stays high from reset until a start
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= H_IDLE;
      cs_n <= 1'b1;
      sck <= 1'b0;
      hold_n <= 1'b1;
      bits <= 6'h00;
      sh <= 32'h00000000;
      rx <= 8'h00;
      rx_byte <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        H_IDLE:
          if (start)
          begin
            cs_n <= 1'b0;
            sh <= tx_data;
            bits <= {len_ok, 3'h0};
            state <= H_LEAD;
          end
        H_LEAD:
          if (tick)
            state <= H_LOW;
        H_LOW:
        begin
          // pause pin moves only while sck is low, so it acts at once
          hold_n <= !pause;
          if (tick && hold_n && !pause)
          begin
            sck <= 1'b1;
            state <= H_HIGH;
          end
        end
        H_HIGH:
          if (tick)
          begin
            sck <= 1'b0;
            rx <= {rx[6:0], miso_s2};
            sh <= {sh[30:0], 1'b0};
            bits <= bits - 6'h01;
            state <= (bits == 6'h01) ? H_TAIL : H_LOW;
          end
        H_TAIL:
          // select rises a full half period after sck fell, never with it
          if (tick)
          begin
            cs_n <= 1'b1;
            hold_n <= 1'b1;
            rx_byte <= rx;
            done <= 1'b1;
            state <= H_IDLE;
          end
        default:
          state <= H_IDLE;
      endcase
    end
  end

endmodule

// *** dv/eeprom_link_props.sv ***
// assertions on the link joining the host end and the eeprom end
// assumes ref_clk launches sck, select and pause from the host end
`timescale 1ns/1ps
module eeprom_link_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic miso_oe,
  // device side state
  input wire logic low_supply,
  input wire logic paused,
  input wire logic write_enable_latch,
  input wire logic mem_wr_go,
  input wire logic status_wr_go
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // pause handling seen at the pins
  a_pause_floats_out: assert property (paused |-> !miso_oe)
    else $error("data out driven while paused");
  a_host_keeps_select: assert property (!hold_n |-> !cs_n)
    else $error("select released during pause");
  a_deselect_ends_pause: assert property (cs_n |-> !paused)
    else $error("pause kept while deselected");
  a_low_clock_entry: assert property (!cs_n && !sck && !hold_n |-> paused)
    else $error("pause not entered with clock low");
  a_low_clock_exit: assert property (!cs_n && !sck && hold_n |-> !paused)
    else $error("pause not left with clock low");
  // pause only changes at a clock fall while the clock is high
  a_high_clock_waits: assert property (!cs_n && sck && $past(sck) |-> $stable(paused))
    else $error("pause changed while clock high");
  // supply guard and select timing
  a_supply_aborts: assert property (low_supply |-> !mem_wr_go && !status_wr_go)
    else $error("write issued under low supply");
  a_supply_clears_latch: assert property (low_supply |-> !write_enable_latch)
    else $error("latch kept under low supply");
  a_write_after_select: assert property ($rose(mem_wr_go) || $rose(status_wr_go) |-> cs_n)
    else $error("write issued while selected");
  a_no_joint_rise: assert property ($rose(cs_n) |-> !$rose(sck))
    else $error("select and clock rose together");
  // main scenarios
  c_paused: cover property (paused && !sck);
  c_mem_write: cover property ($rose(mem_wr_go));
  c_status_write: cover property ($rose(status_wr_go));
endmodule

// *** dv/spi_eeprom_hold_and_brownout_guard_tb_top.sv ***
// self-checking bench: host end and eeprom end joined over the link
// assumes a 10 MHz ref_clk; sck is divided from it inside the host end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module spi_eeprom_hold_and_brownout_guard_tb_top;
  import eeprom_link_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b1;
  logic start = 1'b0;
  logic [2:0] len = 3'h1;
  logic [31:0] tx_data = 32'h0;
  logic pause = 1'b0;
  logic low_supply = 1'b0;
  logic eng_busy = 1'b0;
  logic wr_ack = 1'b0;
  logic host_busy, done, mem_wr_go, status_wr_go, write_enable_latch, paused;
  logic [7:0] rx_byte, mem_wr_data, status_wr_data;
  logic [15:0] mem_wr_addr;
  int bad_count = 0;
  int n_tests = 0;

  eeprom_link_if eeprom_link_if_i ();
  spi_host_end spi_host_end_i (.ref_clk(ref_clk), .nrst(nrst), .link(eeprom_link_if_i.host),
    .start(start), .len(len), .tx_data(tx_data), .pause(pause), .busy(host_busy),
    .done(done), .rx_byte(rx_byte));
  spi_eeprom_end spi_eeprom_end_i (.link(eeprom_link_if_i.device), .low_supply(low_supply),
    .busy(eng_busy), .wr_ack(wr_ack), .mem_wr_go(mem_wr_go), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .status_wr_go(status_wr_go), .status_wr_data(status_wr_data),
    .write_enable_latch(write_enable_latch), .paused(paused));
  eeprom_link_props eeprom_link_props_i (.ref_clk(ref_clk), .nrst(nrst),
    .cs_n(eeprom_link_if_i.cs_n), .sck(eeprom_link_if_i.sck), .hold_n(eeprom_link_if_i.hold_n),
    .miso_oe(eeprom_link_if_i.miso_oe), .low_supply(low_supply), .paused(paused),
    .write_enable_latch(write_enable_latch), .mem_wr_go(mem_wr_go),
    .status_wr_go(status_wr_go));

  // 10 MHz reference clock
  always #50 ref_clk = ~ref_clk;

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one frame; pause rises at cycle pz (0 = never) and stays 40 cycles
  task automatic xfer(input logic [2:0] n, input logic [31:0] d, input int pz);
    int c;
    c = 0;
    len <= n;
    tx_data <= d;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    while (done !== 1'b1 && c < 2000)
    begin
      @(posedge ref_clk);
      c++;
      if (c == pz)
        pause <= 1'b1;
      if (pz > 0 && c == pz + 40)
        pause <= 1'b0;
      if (pz > 0 && c == pz + 30)
      begin
        `CHK("paused", 1'b1, paused)
        `CHK("miso_oe", 1'b0, eeprom_link_if_i.miso_oe)
      end
    end
    `CHK("done", 1'b1, done)
    `CHK("host_busy", 1'b0, host_busy)
    `CHK("cs_n", 1'b1, eeprom_link_if_i.cs_n)
    @(posedge ref_clk);
  endtask

  // main sequence; supply is low through power-up
  initial
  begin
    // reset edges made after all processes run, so the async resets see them
    nrst <= 1'b0;
    low_supply <= 1'b1;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    low_supply <= 1'b0;
    @(posedge ref_clk);
    `CHK("latch", 1'b0, write_enable_latch)
    xfer(3'h4, {CMD_MEM_WR, 24'h0012a5}, 0);
    `CHK("mem_go", 1'b0, mem_wr_go)
    xfer(3'h1, {CMD_WR_ENABLE, 24'h0}, 0);
    `CHK("latch", 1'b1, write_enable_latch)
    // the pause lands mid address; the frame must resume unchanged
    xfer(3'h4, {CMD_MEM_WR, 24'h1234a5}, 150);
    `CHK("mem_go", 1'b1, mem_wr_go)
    `CHK("mem_addr", 16'h1234, mem_wr_addr)
    `CHK("mem_data", 8'ha5, mem_wr_data)
    xfer(3'h1, {CMD_WR_ENABLE, 24'h0}, 0);
    // busy engine shows in bit 0; pause falls inside the answer byte
    eng_busy <= 1'b1;
    xfer(3'h2, {CMD_STATUS_RD, 24'h0}, 120);
    `CHK("status", 8'h03, rx_byte)
    eng_busy <= 1'b0;
    // supply dip drops the pending write and the latch
    `CHK("mem_go", 1'b1, mem_wr_go)
    low_supply <= 1'b1;
    @(posedge ref_clk);
    low_supply <= 1'b0;
    @(posedge ref_clk);
    `CHK("mem_go", 1'b0, mem_wr_go)
    `CHK("latch", 1'b0, write_enable_latch)
    xfer(3'h2, {CMD_STATUS_WR, 24'h8c0000}, 0);
    `CHK("sr_go", 1'b0, status_wr_go)
    xfer(3'h1, {CMD_WR_ENABLE, 24'h0}, 0);
    xfer(3'h2, {CMD_STATUS_WR, 24'h8c0000}, 0);
    `CHK("sr_go", 1'b1, status_wr_go)
    `CHK("sr_data", 8'h8c, status_wr_data)
    wr_ack <= 1'b1;
    @(posedge ref_clk);
    wr_ack <= 1'b0;
    @(posedge ref_clk);
    `CHK("sr_go", 1'b0, status_wr_go)
    give_verdict();
  end

  // watchdog: the sequence needs about 1550 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end
endmodule
